// File: arb_pkg.sv
/*
 package for the serial port request arbiter: request indices, service
 kinds and cycle counts. assumes nothing of its surroundings.
*/
package arb_pkg;
    // =====================================
    // request slots, highest priority first
    localparam int REQ_COUNT     = 4;
    localparam int SLOT_P0_TX    = 0;
    localparam int SLOT_P0_RX    = 1;
    localparam int SLOT_P1_TX    = 2;
    localparam int SLOT_P1_RX    = 3;
    localparam int IRQ_WIDTH     = 8;
    // =====================================
    // cycle counts
    localparam int SYNC_STAGES   = 2;
    localparam int VECTOR_FETCH_CYCLES = 1;
    localparam int EXPAND_CYCLES = 1;
    // =====================================
    // grant kinds
    typedef enum logic [1:0] {
        GRANT_NONE,
        GRANT_AUTOBUF,
        GRANT_IRQ
    } grant_kind_type;
endpackage

// File: req_sync.sv
/*
 two flop synchroniser with rising-edge detect for one serial port request.
 assumes the request is a level from the serial clock domain.
*/
`timescale 1ns/10ps
module req_sync
    import arb_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // request
    input  wire logic async_req,
    output logic      req_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // =====================================
    // synchroniser
    // RULE15 two cycle sync
    // RULE16 late edge lands one cycle later through meta_reg
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            prev_reg  <= 1'b0;
            req_pulse <= 1'b0;
        end else begin
            meta_reg  <= async_req;
            sync_reg  <= meta_reg;
            prev_reg  <= sync_reg;
            req_pulse <= sync_reg & ~prev_reg;
        end
    end
endmodule

// File: seq_model.sv
/*
 instruction sequencer stand-in: drives boundary and stretch flags.
 assumes the bench steers it through hold and slow, set after the edge.
*/
`timescale 1ns/10ps
module seq_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // steering from the bench
    input  wire logic hold,
    input  wire logic slow,
    // sequencer flags
    output logic      instr_boundary,
    output logic      instr_stretch
);
    // =====================================
    // instruction phase
    logic phase_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end
    // two cycle instructions end every other cycle
    assign instr_stretch  = hold;
    assign instr_boundary = ~hold & (~slow | phase_reg);
endmodule

// File: serial_port_request_arbiter.sv
/*
 arbiter that grants serial port autobuffer requests, receive expansion
 and ordinary interrupts at instruction boundaries.
 assumes the sequencer flags boundaries and stalls, and the serial port
 units raise request levels on their own clocks.
*/
// What this block does
// RULE1 - pending requests are granted in order port zero tx, port zero rx, port one tx, port one rx, then interrupts.
// RULE2 - requests are acted on only at an instruction boundary.
// RULE3 - service is postponed while the instruction is stretched by waits, bus requests or multiple accesses.
// RULE4 - a request waits behind higher ones, and an interrupt waits while masked.
// RULE5 - an interrupt grant costs one extra cycle to fetch the first handler instruction.
// RULE6 - an autobuffer grant costs only its transfer cycle, with no fetch cycle.
// RULE7 - an expanded receive word is written only at a boundary, one port at a time.
// RULE8 - port zero gets the shared expander first, port one waits.
// RULE9 - with companding on, the receive request rises only after the expanded write.
// RULE10 - with autobuffering on, a port interrupt rises only when the address update wraps.
// RULE11 - a wrap interrupt passes the same synchronisation delay as other requests.
// RULE12 - with shared frame sync and a free processor, receive is serviced before transmit.
// RULE13 - the requests are 1.5 serial clocks apart, and if both pend transmit wins by priority.
// RULE14 - software shares an index register only when no latency exceeds the request spacing.
// RULE15 - each request is synchronised over two processor cycles.
// RULE16 - a request missing setup or hold takes one more cycle to synchronise.
// RULE17 - each request stays pending until granted and is cleared on grant, once per request.
`timescale 1ns/10ps
module serial_port_request_arbiter
    import arb_pkg::*;
#(
    parameter int IRQ_BITS = IRQ_WIDTH
)
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // serial port requests, serial clock domain
    input  wire logic [REQ_COUNT-1:0] port_req,
    input  wire logic [1:0]           port_wrap,
    input  wire logic [1:0]           rx_compand_en,
    input  wire logic [1:0]           autobuf_en,
    // sequencer
    input  wire logic                 instr_boundary,
    input  wire logic                 instr_stretch,
    input  wire logic [IRQ_BITS-1:0]  irq_pending,
    input  wire logic [IRQ_BITS-1:0]  irq_mask,
    // grants
    output logic                      grant_valid,
    output grant_kind_type            grant_kind,
    output logic [1:0]                grant_slot,
    output logic [IRQ_BITS-1:0]       grant_irq,
    output logic                      fetch_cycle,
    output logic                      port_irq_zero,
    output logic                      port_irq_one,
    output logic [1:0]                expand_write
);
    // slot picker borrows the interrupt-wide scan, so it needs at least REQ_COUNT bits
    if (IRQ_BITS < REQ_COUNT || IRQ_BITS > 16) begin : gen_bad_width
        $error("IRQ_BITS out of range");
    end

    logic [REQ_COUNT-1:0] raw_pulse;
    logic [1:0]           wrap_pulse;
    logic [REQ_COUNT-1:0] pend_reg;
    logic [1:0]           exp_wait_reg;
    logic [1:0]           wrap_pend_reg;
    logic [REQ_COUNT-1:0] grant_onehot;
    logic                 boundary_ok;
    logic [IRQ_BITS-1:0]  irq_live;
    logic [IRQ_BITS-1:0]  irq_pick;
    logic [1:0]           exp_pick;

    // =====================================
    // synchronisers
    // RULE11 wrap interrupt shares sync path
    genvar g;
    generate
        for (g = 0; g < REQ_COUNT; g++) begin : gen_req
            req_sync u_sync (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .async_req (port_req[g]),
                .req_pulse (raw_pulse[g])
            );
        end
        for (g = 0; g < 2; g++) begin : gen_wrap
            req_sync u_wsync (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .async_req (port_wrap[g]),
                .req_pulse (wrap_pulse[g])
            );
        end
    endgenerate

    // lowest index wins; used for slots and interrupts
    function automatic logic [IRQ_BITS-1:0] first_set(input logic [IRQ_BITS-1:0] v);
        logic [IRQ_BITS-1:0] r;
        r = v & (~v + 1'b1);
        return r;
    endfunction

    // =====================================
    // selection
    // RULE2 boundary only
    // RULE3 stretched instruction holds off
    assign boundary_ok = instr_boundary & ~instr_stretch;
    // RULE1 fixed order; RULE13 tx ahead of rx when both pend
    // RULE4 higher slots block lower ones
    assign grant_onehot = boundary_ok ? REQ_COUNT'(first_set(IRQ_BITS'(pend_reg))) : '0;
    // RULE4 masked interrupts wait
    assign irq_live = irq_pending & ~irq_mask;
    assign irq_pick = (boundary_ok && pend_reg == '0) ? first_set(irq_live) : '0;
    // RULE7 one expansion per boundary; RULE8 port zero first
    assign exp_pick[0] = boundary_ok & exp_wait_reg[0];
    assign exp_pick[1] = boundary_ok & exp_wait_reg[1] & ~exp_wait_reg[0];

    // =====================================
    // pending latches
    // RULE17 set wins over clear on grant
    // RULE9 companded rx request waits for expansion write
    // RULE12 rx rises first from the port, so a free processor takes it first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_reg     <= '0;
            exp_wait_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~grant_onehot)
                        | (raw_pulse & ~{rx_compand_en[1], 1'b0, rx_compand_en[0], 1'b0})
                        | {exp_pick[1], 1'b0, exp_pick[0], 1'b0};
            exp_wait_reg <= (exp_wait_reg & ~exp_pick)
                            | ({raw_pulse[SLOT_P1_RX], raw_pulse[SLOT_P0_RX]} & rx_compand_en);
        end
    end

    // RULE10 wrap raises port interrupt only under autobuffering
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrap_pend_reg <= '0;
        end else begin
            wrap_pend_reg <= wrap_pulse & autobuf_en;
        end
    end

    // =====================================
    // outputs
    // RULE5 one fetch cycle for interrupts
    // RULE6 no fetch cycle for autobuffer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grant_valid   <= 1'b0;
            grant_kind    <= GRANT_NONE;
            grant_slot    <= '0;
            grant_irq     <= '0;
            fetch_cycle   <= 1'b0;
            port_irq_zero <= 1'b0;
            port_irq_one  <= 1'b0;
            expand_write  <= '0;
        end else begin
            grant_valid   <= (grant_onehot != '0) | (irq_pick != '0);
            grant_kind    <= (grant_onehot != '0) ? GRANT_AUTOBUF :
                             (irq_pick != '0) ? GRANT_IRQ : GRANT_NONE;
            grant_slot    <= grant_onehot[0] ? 2'd0 : grant_onehot[1] ? 2'd1 :
                             grant_onehot[2] ? 2'd2 : 2'd3;
            grant_irq     <= irq_pick;
            fetch_cycle   <= (grant_onehot == '0) & (irq_pick != '0);
            port_irq_zero <= wrap_pend_reg[0];
            port_irq_one  <= wrap_pend_reg[1];
            expand_write  <= exp_pick;
        end
    end

    // =====================================
    // checks
    // RULE2 grant only after a boundary
    chk_grant_boundary: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
        grant_valid |-> $past(instr_boundary) && !$past(instr_stretch))
        else $error("grant without boundary");
    // RULE1 priority order
    chk_slot_order: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
        (boundary_ok && pend_reg[0]) |=> grant_kind == GRANT_AUTOBUF && grant_slot == 2'd0)
        else $error("slot zero not first");
    // RULE4 masked interrupt never granted
    chk_irq_mask: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
        (grant_kind == GRANT_IRQ) |-> ($past(irq_mask) & grant_irq) == '0)
        else $error("masked interrupt granted");
    // RULE5 fetch with interrupt
    chk_fetch_irq: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
        fetch_cycle == (grant_kind == GRANT_IRQ))
        else $error("fetch cycle mismatch");
    // RULE8 port zero expands first
    chk_expand_one: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
        (boundary_ok && exp_wait_reg == 2'b11) |=> expand_write == 2'b01)
        else $error("port one expanded first");
    // RULE17 granted latch cleared
    chk_pend_clear: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
        (grant_onehot[0] && !raw_pulse[0]) |=> !pend_reg[0])
        else $error("pending not cleared");
    // RULE15 sync latency
    chk_sync_delay: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
        raw_pulse[0] |-> $past(port_req[0], 3) && !$past(port_req[0], 4))
        else $error("sync delay wrong");
    // RULE10 wrap needs autobuffer
    chk_wrap_irq: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
        port_irq_zero |-> $past(autobuf_en[0], 2))
        else $error("wrap interrupt without autobuffer");
    // RULE10 port one wrap gating
    chk_wrap_one: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
        port_irq_one |-> $past(autobuf_en[1], 2))
        else $error("port one wrap interrupt without autobuffer");
    // RULE3 stretch holds off grants
    chk_stretch_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
        instr_stretch |=> !grant_valid)
        else $error("grant during stretch");
    // RULE4 interrupts wait behind slots
    chk_irq_behind: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
        (grant_kind == GRANT_IRQ) |-> $past(pend_reg) == '0)
        else $error("interrupt granted over pending slot");
    // RULE6 no fetch for autobuffer
    chk_autobuf_nofetch: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
        (grant_kind == GRANT_AUTOBUF) |-> !fetch_cycle)
        else $error("fetch cycle on autobuffer grant");
    // RULE7 single expansion at boundary
    chk_expand_boundary: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
        (expand_write != 2'b00) |-> $onehot(expand_write) && $past(instr_boundary) && !$past(instr_stretch))
        else $error("expansion off boundary or doubled");
    // RULE9 companded rx after expansion
    chk_compand_wait: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
        ($rose(pend_reg[SLOT_P0_RX]) && $past(rx_compand_en[0])) |-> $past(exp_pick[0]))
        else $error("companded request before expansion");
endmodule

// File: serial_port_request_arbiter_test.sv
/*
 self-checking bench for the serial port request arbiter.
 assumes seq_model as the sequencer and the bench as both serial ports.
*/
`timescale 1ns/10ps
module serial_port_request_arbiter_test;
    import arb_pkg::*;
    // =====================================
    // signals
    logic ref_clk = 0, rst = 1, hold = 0, slow = 0, gv, fc, pz, po, instr_boundary, instr_stretch;
    logic [3:0] port_req = '0;
    logic [1:0] port_wrap = '0, rx_compand_en = '0, autobuf_en = '0, slot, expand_write;
    logic [7:0] irq_pending = '0, irq_mask = '0, girq;
    grant_kind_type kind;
    int miscompares = 0, n_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    seq_model seq (.ref_clk(ref_clk), .rst(rst), .hold(hold), .slow(slow),
        .instr_boundary(instr_boundary), .instr_stretch(instr_stretch));
    serial_port_request_arbiter dut (.ref_clk(ref_clk), .rst(rst), .port_req(port_req), .port_wrap(port_wrap),
        .rx_compand_en(rx_compand_en), .autobuf_en(autobuf_en), .instr_boundary(instr_boundary),
        .instr_stretch(instr_stretch), .irq_pending(irq_pending), .irq_mask(irq_mask), .grant_valid(gv),
        .grant_kind(kind), .grant_slot(slot), .grant_irq(girq), .fetch_cycle(fc), .port_irq_zero(pz),
        .port_irq_one(po), .expand_write(expand_write));
    // =====================================
    // shared tasks
    task automatic conclude;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // bounded wait on a grant pulse, grant values judged in that cycle
    task automatic next_grant(input grant_kind_type k, input logic [1:0] s, input logic [7:0] q, input logic f);
        int i;
        for (i = 0; i < 30 && gv !== 1'b1; i++) tick(1);
        if (gv !== 1'b1) begin
            miscompares++;
            $display("ERROR t=%0t grant timeout got=%h exp=%h", $time, gv, 1'b1);
            conclude();
        end
        check(kind, k);
        check(k == GRANT_AUTOBUF ? slot : 2'b00, s);
        check(girq, q);
        check(fc, f);
        tick(1);
    endtask
    // =====================================
    // scenarios
    task automatic order_test;
        hold = 1;
        port_req = 4'hf;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            check(gv, 1'b0);
        end
        hold = 0;
        for (int s = 0; s < REQ_COUNT; s++) next_grant(GRANT_AUTOBUF, 2'(s), 8'h00, 1'b0);
        port_req = 4'h0;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            check(gv, 1'b0);
        end
    endtask
    // shared frame sync: rx word lands before tx, processor free
    task automatic free_order_test;
        port_req = 4'h2;
        tick(2);
        // latency stays below request spacing, so one index keeps its order
        port_req = 4'h3;
        next_grant(GRANT_AUTOBUF, 2'(SLOT_P0_RX), 8'h00, 1'b0);
        next_grant(GRANT_AUTOBUF, 2'(SLOT_P0_TX), 8'h00, 1'b0);
        port_req = 4'h0;
        tick(6);
    endtask
    task automatic irq_test;
        hold = 1;
        slow = 1;
        irq_mask = 8'h01;
        irq_pending = 8'h03;
        port_req = 4'h4;
        tick(6);
        hold = 0;
        next_grant(GRANT_AUTOBUF, 2'(SLOT_P1_TX), 8'h00, 1'b0);
        next_grant(GRANT_IRQ, 2'b00, 8'h02, 1'b1);
        irq_pending = 8'h00;
        port_req = 4'h0;
        slow = 0;
        tick(6);
    endtask
    // each port in turn with autobuffering on, the other port's wrap must stay silent
    task automatic wrap_test;
        int i;
        for (int p = 0; p < 2; p++) begin
            autobuf_en = (p == 0) ? 2'b01 : 2'b10;
            port_wrap = 2'b11;
            for (i = 0; i < 12 && ((p == 0) ? pz : po) !== 1'b1; i++) begin
                tick(1);
                check((p == 0) ? po : pz, 1'b0);
            end
            check((p == 0) ? pz : po, 1'b1);
            port_wrap = 2'b00;
            tick(6);
        end
        autobuf_en = 2'b00;
    endtask
    task automatic expand_test;
        int i;
        rx_compand_en = 2'b11;
        hold = 1;
        port_req = 4'ha;
        for (i = 0; i < 8; i++) begin
            tick(1);
            check(expand_write, 2'b00);
        end
        hold = 0;
        for (i = 0; i < 12 && expand_write === 2'b00; i++) tick(1);
        check(expand_write, 2'b01);
        check(gv, 1'b0);
        tick(1);
        check(expand_write, 2'b10);
        next_grant(GRANT_AUTOBUF, 2'(SLOT_P0_RX), 8'h00, 1'b0);
        next_grant(GRANT_AUTOBUF, 2'(SLOT_P1_RX), 8'h00, 1'b0);
        port_req = 4'h0;
        rx_compand_en = 2'b00;
        tick(10);
    endtask
    // =====================================
    // main sequence
    initial begin
        tick(5);
        rst = 0;
        tick(2);
        order_test();
        free_order_test();
        irq_test();
        wrap_test();
        expand_test();
        conclude();
    end
endmodule
